// File: common/ledeng_pkg.sv
// shared constants and types of the led engine driver control block
package ledeng_pkg;
  localparam int NCH = 9;
  localparam int NENG = 3;
  localparam int CLK_HZ = 10_000_000;
  localparam int PWM_HZ = 20_000;
  localparam int PWM_CYC = CLK_HZ / PWM_HZ;
  localparam logic [8:0] PWM_LAST = 9'(PWM_CYC - 1);
  localparam logic [7:0] A_CUR = 8'h00;
  localparam logic [7:0] A_PWMH = 8'h10;
  localparam logic [7:0] A_PWML = 8'h20;
  localparam logic [7:0] A_TEST = 8'h33;
  localparam logic [7:0] A_OWN = 8'h40;
  localparam logic [7:0] A_RUN = 8'h50;
  localparam logic [7:0] A_STEP = 8'h51;
  localparam logic [7:0] A_FADER = 8'h54;
  localparam logic [7:0] A_FAULT = 8'h55;
  localparam logic [7:0] A_FLT_A = 8'h81;
  localparam logic [7:0] A_FLT_B = 8'h82;
  localparam int OPEN_BIT = 0;
  localparam int SHORT_BIT = 1;
  localparam logic [6:0] SLAVE_BASE = 7'h30; // arbitrary base address, low three bits from pins
  localparam int NSYNC = 20;
  typedef struct packed {
    logic temp_hot;   // junction above shutdown threshold
    logic temp_warm;  // junction above release threshold
    logic vin_uv;     // input supply below lockout threshold
    logic vin_ok;     // input supply above recovery threshold
    logic por_low;    // input or core supply below reset threshold
    logic cp_boost;   // headroom too small for unity pump gain
  } ledeng_mon_t;
  typedef struct packed {
    logic [NCH-1:0] led_on;
    logic cp_enable;
    logic cp_gain_1p5;
    logic power_save;
    logic shutdown;
  } ledeng_drv_t;
  typedef enum {I_IDLE, I_ADDR, I_AACK, I_REG, I_RACK, I_WR, I_WACK, I_RD, I_MACK} ledeng_i2c_st_t;
endpackage : ledeng_pkg

// File: src/ledeng_ctrl.sv
// led engine driver control: serial register slave, dimming, engines and protection
// What this block does
// [RL1] each of nine outputs has an 8-bit maximum current register
// [RL2] 20 kHz pwm per output, 12-bit duty via 3-bit dither over base counter
// [RL3] host sets each output's brightness directly over the serial interface
// [RL4] three engines, each may drive any set of one to nine outputs
// [RL5] an output belongs to at most one engine at a time
// [RL6] any engine may be chosen as master fader scaling all engine outputs
// [RL7] charge pump gain adapts between unity and one and a half
// [RL8] power save is entered while no output is active and left otherwise
// [RL9] over-temperature shuts down until temperature falls below release level
// [RL10] undervoltage turns off outputs and pump and sets the fault flag
// [RL11] after undervoltage, operation resumes only above the higher recovery level
// [RL12] while input or core supply is low, internal reset holds the block disabled
// [RL13] led fault flags update only while open or short test enable is set
// [RL14] host enables at most one of the two led test bits
// [RL15] led fault results are read at offsets 81h and 82h
// [RL16] host uses the led fault tests for production testing only
// [RL17] slave address has three pin-selected bits, eight drivers per bus
// [RL18] undervoltage fault flag stays set until the host reads the fault register
`timescale 1ns/10ps
module ledeng_ctrl (
  input wire logic mclk,                              // 10 MHz clock
  input wire logic reset,                             // synchronous, active high
  input wire logic scl,                               // serial clock pin
  input wire logic sda_in,                            // serial data pin level
  output logic sda_out,                               // serial data drive value, always low
  output logic sda_oe,                                // high while pulling data low
  input wire logic [2:0] addr_sel,                    // address select pins
  input wire ledeng_pkg::ledeng_mon_t mon,            // analog monitor comparators
  input wire logic [ledeng_pkg::NCH-1:0] led_fault,   // per-output comparator result of running test
  output ledeng_pkg::ledeng_drv_t drv,                // sink, pump and mode controls
  output logic [ledeng_pkg::NCH*8-1:0] led_current    // per-output current codes
);
  ////////////////////////////////////////////////////////////////////////////
  logic [ledeng_pkg::NSYNC-1:0] raw, s1_q, s2_q, s3_q, f_q;
  ledeng_pkg::ledeng_mon_t mon_f;
  logic scl_f, sda_f, scl_p_q, sda_p_q, por, off;
  logic [2:0] asel_f;
  logic [ledeng_pkg::NCH-1:0] flt_in_f;
  assign raw = {scl, sda_in, addr_sel, mon, led_fault};
  assign {scl_f, sda_f, asel_f, mon_f, flt_in_f} = f_q;
  // three-stage synchroniser; a change is taken once stages two and three agree
  always_ff @(posedge mclk) begin
    s1_q <= raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  for (genvar b = 0; b < ledeng_pkg::NSYNC; b++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (reset) f_q[b] <= 1'b1;
      else if (s2_q[b] == s3_q[b]) f_q[b] <= s3_q[b];
    end
  end
  assign por = mon_f.por_low; // [RL12]
  ////////////////////////////////////////////////////////////////////////////
  // serial slave
  ledeng_pkg::ledeng_i2c_st_t st_q;
  logic [7:0] sh_q, ptr_q, rdata, wr_a_q, wr_d_q;
  logic [3:0] cnt_q;
  logic rw_q, nack_q, wr_q, rd_clr_q, start, stop, rise, fall;
  assign start = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign rise = scl_f & ~scl_p_q;
  assign fall = ~scl_f & scl_p_q;
  assign sda_out = 1'b0;
  // byte engine; the bus is open drain so only a low level is ever driven
  always_ff @(posedge mclk) begin
    scl_p_q <= scl_f;
    sda_p_q <= sda_f;
    wr_q <= 1'b0;
    rd_clr_q <= 1'b0;
    if (reset || por || stop) begin
      st_q <= ledeng_pkg::I_IDLE;
      sda_oe <= 1'b0;
      cnt_q <= 4'h0;
    end else if (start) begin
      st_q <= ledeng_pkg::I_ADDR;
      sda_oe <= 1'b0;
      cnt_q <= 4'h0;
    end else if (rise) begin
      sh_q <= {sh_q[6:0], sda_f};
      cnt_q <= cnt_q + 4'h1;
      if (st_q == ledeng_pkg::I_MACK) nack_q <= sda_f;
    end else if (fall) begin
      case (st_q)
        ledeng_pkg::I_ADDR: if (cnt_q == 4'h8) begin
          if (sh_q[7:1] == {ledeng_pkg::SLAVE_BASE[6:3], asel_f}) begin // [RL17]
            st_q <= ledeng_pkg::I_AACK;
            sda_oe <= 1'b1;
            rw_q <= sh_q[0];
          end else st_q <= ledeng_pkg::I_IDLE;
        end
        ledeng_pkg::I_AACK, ledeng_pkg::I_MACK: begin
          cnt_q <= 4'h0;
          if (st_q == ledeng_pkg::I_MACK && nack_q) begin
            st_q <= ledeng_pkg::I_IDLE;
            sda_oe <= 1'b0;
          end else if (rw_q) begin
            st_q <= ledeng_pkg::I_RD;
            sh_q <= rdata;
            sda_oe <= ~rdata[7];
            rd_clr_q <= (ptr_q == ledeng_pkg::A_FAULT); // [RL18]
          end else begin
            st_q <= ledeng_pkg::I_REG;
            sda_oe <= 1'b0;
          end
        end
        ledeng_pkg::I_REG, ledeng_pkg::I_WR: if (cnt_q == 4'h8) begin
          st_q <= (st_q == ledeng_pkg::I_REG) ? ledeng_pkg::I_RACK : ledeng_pkg::I_WACK;
          sda_oe <= 1'b1;
          if (st_q == ledeng_pkg::I_REG) ptr_q <= sh_q;
          else begin
            wr_q <= 1'b1; // [RL3]
            wr_a_q <= ptr_q;
            wr_d_q <= sh_q;
            ptr_q <= ptr_q + 8'h01;
          end
        end
        ledeng_pkg::I_RACK, ledeng_pkg::I_WACK: begin
          st_q <= ledeng_pkg::I_WR;
          sda_oe <= 1'b0;
          cnt_q <= 4'h0;
        end
        ledeng_pkg::I_RD: if (cnt_q == 4'h8) begin
          st_q <= ledeng_pkg::I_MACK;
          sda_oe <= 1'b0;
          ptr_q <= ptr_q + 8'h01;
        end else sda_oe <= ~sh_q[7];
        default: sda_oe <= 1'b0;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] cur_q [ledeng_pkg::NCH];
  logic [7:0] pwmh_q [ledeng_pkg::NCH];
  logic [3:0] pwml_q [ledeng_pkg::NCH];
  logic [1:0] own_q [ledeng_pkg::NCH];
  logic [7:0] step_q [ledeng_pkg::NENG];
  logic [7:0] lvl_q [ledeng_pkg::NENG];
  logic [2:0] run_q;
  logic [1:0] fader_q, test_q;
  logic [7:0] flt_a_q, flt_b_q;
  logic flt_uv_q, uv_q, tsd_q, wr_hit;
  // host registers; supply reset returns everything to the disabled state
  always_ff @(posedge mclk) begin
    if (reset || por) begin // [RL12]
      for (int i = 0; i < ledeng_pkg::NCH; i++) begin
        cur_q[i] <= 8'h00;
        pwmh_q[i] <= 8'h00;
        pwml_q[i] <= 4'h0;
        own_q[i] <= 2'h0;
      end
      for (int e = 0; e < ledeng_pkg::NENG; e++) step_q[e] <= 8'h00;
      run_q <= 3'h0;
      fader_q <= 2'h0;
      test_q <= 2'h0;
    end else if (wr_q) begin
      for (int i = 0; i < ledeng_pkg::NCH; i++) begin
        if (wr_a_q == ledeng_pkg::A_CUR + 8'(i)) cur_q[i] <= wr_d_q; // [RL1]
        if (wr_a_q == ledeng_pkg::A_PWMH + 8'(i)) pwmh_q[i] <= wr_d_q; // [RL3]
        if (wr_a_q == ledeng_pkg::A_PWML + 8'(i)) pwml_q[i] <= wr_d_q[3:0];
        if (wr_a_q == ledeng_pkg::A_OWN + 8'(i)) own_q[i] <= wr_d_q[1:0]; // [RL4] [RL5]
      end
      for (int e = 0; e < ledeng_pkg::NENG; e++)
        if (wr_a_q == ledeng_pkg::A_STEP + 8'(e)) step_q[e] <= wr_d_q;
      if (wr_a_q == ledeng_pkg::A_RUN) run_q <= wr_d_q[2:0];
      if (wr_a_q == ledeng_pkg::A_FADER) fader_q <= wr_d_q[1:0]; // [RL6]
      if (wr_a_q == ledeng_pkg::A_TEST) test_q <= wr_d_q[1:0]; // [RL14]
    end
  end
  assign wr_hit = test_q[ledeng_pkg::OPEN_BIT] | test_q[ledeng_pkg::SHORT_BIT];
  // fault state; of the two resets only the main reset clears latched faults so a supply dip is remembered
  always_ff @(posedge mclk) begin
    if (reset) begin
      uv_q <= 1'b0;
      tsd_q <= 1'b0;
      flt_uv_q <= 1'b0;
      flt_a_q <= 8'h00;
      flt_b_q <= 8'h00;
    end else begin
      if (mon_f.vin_uv) uv_q <= 1'b1; // [RL10]
      else if (mon_f.vin_ok) uv_q <= 1'b0; // [RL11]
      if (mon_f.temp_hot) tsd_q <= 1'b1; // [RL9]
      else if (!mon_f.temp_warm) tsd_q <= 1'b0;
      if (uv_q) flt_uv_q <= 1'b1; // set wins over read clear [RL18]
      else if (rd_clr_q) flt_uv_q <= 1'b0;
      if (wr_hit) begin // [RL13] [RL16]
        flt_a_q <= flt_in_f[7:0];
        flt_b_q <= {7'h00, flt_in_f[8]};
      end
    end
  end
  // read data multiplexer; unmapped offsets read zero
  always_comb begin
    rdata = 8'h00;
    for (int i = 0; i < ledeng_pkg::NCH; i++) begin
      if (ptr_q == ledeng_pkg::A_CUR + 8'(i)) rdata = cur_q[i];
      if (ptr_q == ledeng_pkg::A_PWMH + 8'(i)) rdata = pwmh_q[i];
      if (ptr_q == ledeng_pkg::A_PWML + 8'(i)) rdata = {4'h0, pwml_q[i]};
      if (ptr_q == ledeng_pkg::A_OWN + 8'(i)) rdata = {6'h00, own_q[i]};
    end
    for (int e = 0; e < ledeng_pkg::NENG; e++)
      if (ptr_q == ledeng_pkg::A_STEP + 8'(e)) rdata = step_q[e];
    if (ptr_q == ledeng_pkg::A_RUN) rdata = {5'h00, run_q};
    if (ptr_q == ledeng_pkg::A_FADER) rdata = {6'h00, fader_q};
    if (ptr_q == ledeng_pkg::A_TEST) rdata = {6'h00, test_q};
    if (ptr_q == ledeng_pkg::A_FAULT) rdata = {4'h0, drv.power_save, drv.cp_gain_1p5, tsd_q, flt_uv_q};
    if (ptr_q == ledeng_pkg::A_FLT_A) rdata = flt_a_q; // [RL15]
    if (ptr_q == ledeng_pkg::A_FLT_B) rdata = flt_b_q; // [RL15]
  end
  ////////////////////////////////////////////////////////////////////////////
  logic [8:0] pcnt_q;
  logic [2:0] frame_q;
  logic pend;
  logic [ledeng_pkg::NCH-1:0] on, act;
  assign pend = (pcnt_q == ledeng_pkg::PWM_LAST);
  assign off = tsd_q | uv_q | por;
  // 500-cycle base period gives 20 kHz; the frame count walks the dither phase
  always_ff @(posedge mclk) begin
    if (reset) begin
      pcnt_q <= 9'h000;
      frame_q <= 3'h0;
    end else begin
      pcnt_q <= pend ? 9'h000 : pcnt_q + 9'h001; // [RL2]
      if (pend) frame_q <= frame_q + 3'h1;
    end
  end
  // engines step their triangle level once per pwm period while running
  for (genvar e = 0; e < ledeng_pkg::NENG; e++) begin : g_eng
    logic dn_q;
    always_ff @(posedge mclk) begin
      if (reset || por || !run_q[e]) begin // [RL4]
        lvl_q[e] <= 8'h00;
        dn_q <= 1'b0;
      end else if (pend) begin
        if (!dn_q && lvl_q[e] > 8'hFF - step_q[e]) begin
          lvl_q[e] <= 8'hFF;
          dn_q <= 1'b1;
        end else if (dn_q && lvl_q[e] < step_q[e]) begin
          lvl_q[e] <= 8'h00;
          dn_q <= 1'b0;
        end else lvl_q[e] <= dn_q ? lvl_q[e] - step_q[e] : lvl_q[e] + step_q[e];
      end
    end
  end
  // per-output duty: one owner field, so two engines can never claim one output
  for (genvar i = 0; i < ledeng_pkg::NCH; i++) begin : g_ch
    logic [11:0] src, duty;
    logic [19:0] prod;
    assign src = (own_q[i] == 2'h0) ? {pwmh_q[i], pwml_q[i]} : {lvl_q[own_q[i] - 2'h1], 4'h0}; // [RL5]
    assign prod = src * lvl_q[(fader_q == 2'h0) ? 2'h0 : fader_q - 2'h1];
    assign duty = (fader_q == 2'h0 || own_q[i] == 2'h0) ? src : prod[19:8]; // [RL6]
    assign on[i] = {1'b0, pcnt_q} < {1'b0, duty[11:3]} + {9'h000, duty[2:0] > frame_q}; // [RL2]
    assign act[i] = (duty != 12'h000) && (cur_q[i] != 8'h00);
    assign led_current[i*8 +: 8] = cur_q[i]; // [RL1]
  end
  // output stage; all sinks and the pump drop while a fault holds
  always_ff @(posedge mclk) begin
    if (reset) drv <= '0;
    else begin
      drv.led_on <= off ? '0 : on & act; // [RL10] [RL12]
      drv.power_save <= ~|act; // [RL8]
      drv.cp_enable <= ~off & |act; // [RL10]
      drv.cp_gain_1p5 <= ~off & |act & mon_f.cp_boost; // [RL7]
      drv.shutdown <= off; // [RL9]
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_UV_OFF: assert property (uv_q |=> drv.led_on == '0 && !drv.cp_enable) else $error("outputs on in lockout"); // RL10
  AST_UV_FLAG: assert property (uv_q |=> flt_uv_q) else $error("undervoltage flag not set"); // RL10
  AST_UV_HYST: assert property (uv_q && !mon_f.vin_ok |=> uv_q) else $error("lockout left below recovery"); // RL11
  AST_FLAG_STICK: assert property (flt_uv_q && !rd_clr_q |=> flt_uv_q) else $error("fault flag lost"); // RL18
  AST_TSD: assert property (mon_f.temp_hot |=> tsd_q ##1 drv.shutdown) else $error("no thermal shutdown"); // RL9
  AST_TSD_HOLD: assert property (tsd_q && mon_f.temp_warm |=> tsd_q) else $error("early thermal release"); // RL9
  AST_FLT_FREEZE: assert property (!wr_hit |=> $stable(flt_a_q) && $stable(flt_b_q)) else $error("flags moved"); // RL13
  AST_PSAVE: assert property (!(|act) |=> drv.power_save && drv.led_on == '0) else $error("power save missed"); // RL8
  AST_POR: assert property (por |=> cur_q[0] == 8'h00 && run_q == 3'h0) else $error("registers kept in reset"); // RL12
  AST_PUMP: assert property (drv.cp_gain_1p5 |-> drv.cp_enable) else $error("gain without pump"); // RL7
  COV_WRITE: cover property (wr_q && wr_a_q == ledeng_pkg::A_CUR);
  COV_READ_CLR: cover property (rd_clr_q && flt_uv_q);
  COV_TSD: cover property (tsd_q ##1 !tsd_q);
endmodule : ledeng_ctrl

// File: verification/ledeng_host_model.sv
// host model: two-wire bus master that reaches the driver registers
`timescale 1ns/10ps
module ledeng_host_model (
  input wire logic mclk, // bench clock
  input wire logic sda,  // resolved data wire, pulled up
  output logic scl,      // serial clock, idle high
  output logic sda_low   // high while the host pulls data low
);
  localparam int H = 12; // half bit time in clocks, low phase stays above ten clocks
  logic [6:0] dev_addr;  // slave address aimed at
  logic last_ack;        // acknowledge seen on the first address byte of the last transfer
  ////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    last_ack = 1'b0;
  end
  // every change lands on a falling edge, away from the sampling edge
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask : hold
  // start and repeated start alike: data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    hold(H);
    scl = 1'b1;
    hold(H);
    sda_low = 1'b1;
    hold(H);
    scl = 1'b0;
    hold(4);
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    hold(H);
    scl = 1'b1;
    hold(H);
    sda_low = 1'b0;
    hold(H);
  endtask : stop
  // data is held across the whole clock high phase and sampled at its end
  task automatic bit_io(input logic v, output logic s);
    sda_low = ~v;
    hold(H);
    scl = 1'b1;
    hold(H);
    s = sda;
    scl = 1'b0;
    hold(4);
  endtask : bit_io
  // msb first, then the acknowledge slot; mv is what the host puts there
  task automatic byte_io(input logic [7:0] b, input logic mv, output logic [7:0] r, output logic k);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(mv, s);
    k = ~s;
  endtask : byte_io
  ////////////////////////////////////////////////////////////////////////
  // register write: address, pointer, one data byte
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic k;
    start();
    byte_io({dev_addr, 1'b0}, 1'b1, r, last_ack);
    byte_io(a, 1'b1, r, k);
    byte_io(d, 1'b1, r, k);
    stop();
  endtask : wr_reg
  // register read: pointer write, repeated start, one byte closed by a nack
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    logic k;
    start();
    byte_io({dev_addr, 1'b0}, 1'b1, r, last_ack);
    byte_io(a, 1'b1, r, k);
    start();
    byte_io({dev_addr, 1'b1}, 1'b1, r, k);
    byte_io(8'hFF, 1'b1, d, k);
    stop();
  endtask : rd_reg
endmodule : ledeng_host_model

// File: verification/led_engine_driver_control_bench.sv
// self-checking bench of the led engine driver control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module led_engine_driver_control_bench;
  logic mclk;
  logic reset;
  logic scl;
  logic sda_low;
  wire sda;
  logic sda_oe;
  logic [2:0] addr_sel;
  ledeng_pkg::ledeng_mon_t mon;
  logic [8:0] led_fault;
  ledeng_pkg::ledeng_drv_t drv;
  logic [71:0] led_current;
  logic [7:0] rd;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int ons;
  // open-drain data wire with pull-up: low if either party pulls
  assign sda = ~(sda_low | sda_oe);
  ledeng_ctrl dut_u (.mclk(mclk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .mon(mon), .led_fault(led_fault), .drv(drv), .led_current(led_current));
  ledeng_host_model host_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////////////////////////////////////
  // 10 MHz clock and a cycle ceiling well above the expected run
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle
  // on-time of one output over whole pwm periods of 500 clocks
  task automatic count_on(input int n, input int ch);
    ons = 0;
    repeat (n * 500) begin
      @(negedge mclk);
      ons += int'(drv.led_on[ch]);
    end
  endtask : count_on
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset = 1'b1;
    addr_sel = 3'h5;
    mon = 6'h04;
    led_fault = 9'h000;
    host_u.dev_addr = {ledeng_pkg::SLAVE_BASE[6:3], 3'h5};
    idle(6);
    reset = 1'b0;
    idle(20);
    `CHK("power save idle", 1'b1, drv.power_save)
    host_u.rd_reg(ledeng_pkg::A_FAULT, rd); // drops the start-up undervoltage flag
    for (int i = 0; i < 9; i++) host_u.wr_reg(ledeng_pkg::A_CUR + 8'(i), 8'(i * 17 + 1));
    for (int i = 0; i < 9; i++) begin
      host_u.rd_reg(ledeng_pkg::A_CUR + 8'(i), rd);
      `CHK("current reg", 8'(i * 17 + 1), rd)
      `CHK("current pins", 8'(i * 17 + 1), led_current[i * 8 +: 8])
    end
    `CHK("address ack", 1'b1, host_u.last_ack)
    $display("test currents done");
    host_u.wr_reg(ledeng_pkg::A_PWMH, 8'h80);
    idle(20);
    `CHK("power save active", 1'b0, drv.power_save)
    `CHK("pump on", 1'b1, drv.cp_enable)
    count_on(1, 0);
    `CHK("duty 0x800", 256, ons)
    `CHK("other outputs", 8'h00, drv.led_on[8:1])
    host_u.wr_reg(ledeng_pkg::A_PWML, 8'h04);
    count_on(8, 0);
    `CHK("dithered duty", 2052, ons)
    mon.cp_boost = 1'b1;
    idle(10);
    `CHK("pump gain", 1'b1, drv.cp_gain_1p5)
    mon.cp_boost = 1'b0;
    host_u.wr_reg(ledeng_pkg::A_OWN + 8'h08, 8'h03);
    host_u.rd_reg(ledeng_pkg::A_OWN + 8'h08, rd);
    `CHK("owner", 8'h03, rd)
    host_u.wr_reg(ledeng_pkg::A_FADER, 8'h02);
    host_u.rd_reg(ledeng_pkg::A_FADER, rd);
    `CHK("fader", 8'h02, rd)
    // engine one owns output 1; a full step toggles its level between 0 and 255 every two periods
    host_u.wr_reg(ledeng_pkg::A_OWN + 8'h01, 8'h01);
    host_u.wr_reg(ledeng_pkg::A_STEP, 8'hFF);
    host_u.wr_reg(ledeng_pkg::A_RUN, 8'h01);
    count_on(4, 1);
    `CHK("faded by stopped engine", 0, ons)
    host_u.wr_reg(ledeng_pkg::A_FADER, 8'h00);
    count_on(4, 1);
    `CHK("engine duty", 1000, ons)
    $display("test dimming done");
    led_fault = 9'h1A5;
    host_u.wr_reg(ledeng_pkg::A_TEST, 8'h01);
    host_u.rd_reg(ledeng_pkg::A_FLT_A, rd);
    `CHK("fault a", 8'hA5, rd)
    host_u.rd_reg(ledeng_pkg::A_FLT_B, rd);
    `CHK("fault b", 8'h01, rd)
    host_u.wr_reg(ledeng_pkg::A_TEST, 8'h00);
    led_fault = 9'h05A;
    idle(10);
    host_u.rd_reg(ledeng_pkg::A_FLT_A, rd);
    `CHK("fault frozen", 8'hA5, rd)
    $display("test led faults done");
    mon = 6'h08;
    idle(20);
    `CHK("uv outputs", 9'h000, drv.led_on)
    `CHK("uv pump", 1'b0, drv.cp_enable)
    host_u.rd_reg(ledeng_pkg::A_FAULT, rd);
    `CHK("uv flag", 1'b1, rd[0])
    mon = 6'h00;
    idle(20);
    `CHK("uv hysteresis", 1'b0, drv.cp_enable)
    mon = 6'h04;
    idle(20);
    `CHK("uv recovered", 1'b1, drv.cp_enable)
    host_u.rd_reg(ledeng_pkg::A_FAULT, rd);
    `CHK("uv sticky", 1'b1, rd[0])
    host_u.rd_reg(ledeng_pkg::A_FAULT, rd);
    `CHK("uv cleared", 1'b0, rd[0])
    $display("test undervoltage done");
    mon = 6'h34;
    idle(10);
    `CHK("hot", 1'b1, drv.shutdown)
    mon = 6'h14;
    idle(10);
    `CHK("warm", 1'b1, drv.shutdown)
    `CHK("warm outputs", 9'h000, drv.led_on)
    mon = 6'h04;
    idle(10);
    `CHK("cool", 1'b0, drv.shutdown)
    $display("test thermal done");
    host_u.dev_addr = {ledeng_pkg::SLAVE_BASE[6:3], 3'h2};
    host_u.rd_reg(ledeng_pkg::A_TEST, rd);
    `CHK("foreign address", 1'b0, host_u.last_ack)
    `CHK("foreign data", 8'hFF, rd)
    host_u.dev_addr = {ledeng_pkg::SLAVE_BASE[6:3], 3'h5};
    mon = 6'h06;
    idle(10);
    `CHK("por pins", 72'h0, led_current)
    `CHK("por outputs", 9'h000, drv.led_on)
    mon = 6'h04;
    idle(10);
    host_u.rd_reg(ledeng_pkg::A_PWMH, rd);
    `CHK("por regs", 8'h00, rd)
    $display("test reset and address done");
    report_and_stop();
  end
endmodule : led_engine_driver_control_bench
